/* hw/acm_defs.vh */
// Constants for the audio channel modulation block.
// Included by every design file of the block; definitions only.
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

`define ACM_ADDR_W          8
// Register byte offsets
`define ACM_OFF_ATTACH      8'h00
`define ACM_OFF_DMA_CTRL    8'h04
`define ACM_OFF_FILTER      8'h08
`define ACM_OFF_IRQ_STAT    8'h0C
`define ACM_OFF_IRQ_MASK    8'h10
`define ACM_OFF_CH_BASE     8'h20
`define ACM_CH_STRIDE       8'h10
`define ACM_CH_OFF_LOC      4'h0
`define ACM_CH_OFF_LEN      4'h4
`define ACM_CH_OFF_PER      4'h8
`define ACM_CH_OFF_VOL      4'hC
// Field positions
`define ACM_VOL_ATTACH_LSB  0
`define ACM_PER_ATTACH_LSB  4
`define ACM_MASTER_DMA_BIT  9
`define ACM_VOL_W           7
// Reset values
`define ACM_ATTACH_RST      16'h0000
`define ACM_DMA_CTRL_RST    16'h0000
`define ACM_PER_RST         16'h0000
`define ACM_VOL_RST         7'h00
`define ACM_LOC_W           18
// Timing: one sampling tick every DIV clock cycles
`define ACM_TICK_DIV        8'h46

`endif

/* hw/acm_tick_div.v */
// Divider that makes the audio timing tick as a one-cycle enable.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.vh"

module acm_tick_div (
	input  wire clk_i,
	input  wire sys_rst_i,
	output reg  tick_o
);
	reg [7:0] cnt_q;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_q  <= 8'h00;
			tick_o <= 1'b0;
		end else if (cnt_q == `ACM_TICK_DIV - 8'h01) begin
			cnt_q  <= 8'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hw/acm_chan.v */
// One audio channel: DMA pointer, length, period counter, sample output.
// Assumes fetch data arrives with fetch_ack_i, any number of cycles after fetch_req_o.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.vh"

module acm_chan (
	input  wire                 clk_i,
	input  wire                 sys_rst_i,
	input  wire                 tick_i,
	input  wire                 run_i,
	input  wire                 word_mode_i,
	input  wire [17:0]          loc_i,
	input  wire [15:0]          len_i,
	input  wire [15:0]          per_i,
	output reg                  fetch_req_o,
	output reg  [17:0]          fetch_addr_o,
	input  wire                 fetch_ack_i,
	input  wire [15:0]          fetch_data_i,
	output reg  [15:0]          word_o,
	output reg                  expire_o,
	output reg                  wrap_o,
	output reg                  irq_o,
	output reg                  byte_sel_o
);
	reg [17:0] ptr_q;
	reg [15:0] len_q;
	reg [15:0] per_q;
	reg        live_q;
	reg        wait_q;
	reg        have_q;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ptr_q <= 18'h0_0000;
			len_q <= 16'h0000;
			per_q <= 16'h0000;
			live_q <= 1'b0;
			wait_q <= 1'b0;
			have_q <= 1'b0;
			fetch_req_o <= 1'b0;
			fetch_addr_o <= 18'h0_0000;
			word_o <= 16'h0000;
			expire_o <= 1'b0;
			wrap_o <= 1'b0;
			irq_o <= 1'b0;
			byte_sel_o <= 1'b0;
		end else begin
			fetch_req_o <= 1'b0;
			expire_o <= 1'b0;
			wrap_o <= 1'b0;
			irq_o <= 1'b0;
			if (!run_i) begin
				live_q <= 1'b0;
				have_q <= 1'b0;
				wait_q <= 1'b0;
			end else if (!live_q) begin
				// Copy programmed registers into working copies
				ptr_q <= loc_i;
				len_q <= len_i;
				per_q <= per_i;
				live_q <= 1'b1;
				irq_o <= 1'b1;
			end else begin
				if (!have_q && !wait_q) begin
					fetch_req_o <= 1'b1;
					fetch_addr_o <= ptr_q;
					wait_q <= 1'b1;
				end
				if (fetch_ack_i && wait_q) begin
					word_o <= fetch_data_i;
					wait_q <= 1'b0;
					have_q <= 1'b1;
					byte_sel_o <= 1'b0;
					if (len_q <= 16'h0001) begin
						ptr_q <= loc_i;
						len_q <= len_i;
						wrap_o <= 1'b1;
						irq_o <= 1'b1;
					end else begin
						ptr_q <= ptr_q + 18'h0_0001;
						len_q <= len_q - 16'h0001;
					end
				end
				if (tick_i && have_q) begin
					if (per_q <= 16'h0001) begin
						per_q <= per_i;
						expire_o <= 1'b1;
						if (word_mode_i) begin
							// Modulator word is used whole, one per period
							byte_sel_o <= 1'b0;
							have_q <= 1'b0;
						end else begin
							byte_sel_o <= ~byte_sel_o;
							if (byte_sel_o)
								have_q <= 1'b0;
						end
					end else begin
						per_q <= per_q - 16'h0001;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* hw/acm_top.v */
// Four-channel sampled-audio unit with attach (modulation) logic and APB.
// Assumes an APB master on clk_i and a memory that answers each fetch with fetch_ack_i after any delay.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.vh"

module acm_top (
	input  wire                   clk_i,
	input  wire                   sys_rst_i,
	input  wire                   psel_i,
	input  wire                   penable_i,
	input  wire                   pwrite_i,
	input  wire [`ACM_ADDR_W-1:0] paddr_i,
	input  wire [31:0]            pwdata_i,
	output reg  [31:0]            prdata_o,
	output reg                    pready_o,
	output reg                    pslverr_o,
	output reg  [3:0]             fetch_req_o,
	output reg  [71:0]            fetch_addr_o,
	input  wire [3:0]             fetch_ack_i,
	input  wire [63:0]            fetch_data_i,
	output reg  [31:0]            dac_sample_o,
	output reg  [27:0]            dac_volume_o,
	output reg                    filter_bypass_control_o,
	output reg                    irq_o
);
	////////////////////////////////////////////////////////////////////
	// Registers
	reg [15:0] attach_q;
	reg [15:0] dma_ctrl_q;
	reg [3:0]  irq_stat_q;
	reg [3:0]  irq_mask_q;
	reg [17:0] loc_q [0:3];
	reg [15:0] len_q [0:3];
	reg [15:0] per_q [0:3];
	reg [6:0]  vol_q [0:3];
	reg [3:0]  phase_q;
	reg [3:0]  wrap_pend_q;

	wire        tick;
	wire [3:0]  ch_irq;
	wire [3:0]  ch_exp;
	wire [3:0]  ch_wrap;
	wire [3:0]  ch_req;
	wire [3:0]  ch_bsel;
	wire [71:0] ch_addr;
	wire [63:0] ch_word;
	wire [3:0]  vol_att = attach_q[`ACM_VOL_ATTACH_LSB +: 4];
	wire [3:0]  per_att = attach_q[`ACM_PER_ATTACH_LSB +: 4];
	wire [3:0]  run;

	wire        acc   = psel_i && penable_i;
	wire        wr    = acc && pwrite_i;
	wire        in_ch = paddr_i >= `ACM_OFF_CH_BASE;
	wire [7:0]  ch_rel = paddr_i - `ACM_OFF_CH_BASE;
	wire [1:0]  ch_idx = ch_rel[5:4];
	wire [3:0]  ch_fld = ch_rel[3:0];
	wire        mapped = in_ch ? (ch_rel < 8'h40 && paddr_i[1:0] == 2'b00) :
		(paddr_i == `ACM_OFF_ATTACH || paddr_i == `ACM_OFF_DMA_CTRL ||
		 paddr_i == `ACM_OFF_FILTER || paddr_i == `ACM_OFF_IRQ_STAT ||
		 paddr_i == `ACM_OFF_IRQ_MASK);

	acm_tick_div u_div (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_o    (tick)
	);

	////////////////////////////////////////////////////////////////////
	// Channels
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_ch
			assign run[g] = dma_ctrl_q[`ACM_MASTER_DMA_BIT] && dma_ctrl_q[g];
			acm_chan u_ch (
				.clk_i        (clk_i),
				.sys_rst_i    (sys_rst_i),
				.tick_i       (tick),
				.run_i        (run[g]),
				.word_mode_i  (vol_att[g] || per_att[g]),
				.loc_i        (loc_q[g]),
				.len_i        (len_q[g]),
				.per_i        (per_q[g]),
				.fetch_req_o  (ch_req[g]),
				.fetch_addr_o (ch_addr[g*18 +: 18]),
				.fetch_ack_i  (fetch_ack_i[g]),
				.fetch_data_i (fetch_data_i[g*16 +: 16]),
				.word_o       (ch_word[g*16 +: 16]),
				.expire_o     (ch_exp[g]),
				.wrap_o       (ch_wrap[g]),
				.irq_o        (ch_irq[g]),
				.byte_sel_o   (ch_bsel[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Register writes and modulation
	integer i;
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			attach_q <= `ACM_ATTACH_RST;
			dma_ctrl_q <= `ACM_DMA_CTRL_RST;
			filter_bypass_control_o <= 1'b0;
			irq_stat_q <= 4'h0;
			irq_mask_q <= 4'h0;
			phase_q <= 4'h0;
			wrap_pend_q <= 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				loc_q[i] <= 18'h0_0000;
				len_q[i] <= 16'h0000;
				per_q[i] <= `ACM_PER_RST;
				vol_q[i] <= `ACM_VOL_RST;
			end
		end else begin
			if (wr && mapped && !in_ch) begin
				case (paddr_i)
				`ACM_OFF_ATTACH:   attach_q <= pwdata_i[15:0];
				`ACM_OFF_DMA_CTRL: dma_ctrl_q <= pwdata_i[15:0];
				`ACM_OFF_FILTER:   filter_bypass_control_o <= pwdata_i[1];
				`ACM_OFF_IRQ_MASK: irq_mask_q <= pwdata_i[3:0];
				default: ;
				endcase
			end
			if (wr && mapped && in_ch) begin
				case (ch_fld)
				`ACM_CH_OFF_LOC: loc_q[ch_idx] <= pwdata_i[17:0];
				`ACM_CH_OFF_LEN: len_q[ch_idx] <= pwdata_i[15:0];
				`ACM_CH_OFF_PER: per_q[ch_idx] <= pwdata_i[15:0];
				default:         vol_q[ch_idx] <= pwdata_i[6:0];
				endcase
			end
			// Set wins over write-one-to-clear
			irq_stat_q <= (irq_stat_q & ~((wr && paddr_i == `ACM_OFF_IRQ_STAT) ?
				pwdata_i[3:0] : 4'h0)) | ch_irq;
			// Channels 0..2 modulate the next one; channel 3 has no target
			for (i = 0; i < 3; i = i + 1) begin
				// Wrap comes with the last word; restart after that word is used
				if (ch_wrap[i])
					wrap_pend_q[i] <= 1'b1;
				if (ch_exp[i]) begin
					if (vol_att[i] && per_att[i]) begin
						if (phase_q[i])
							per_q[i+1] <= ch_word[i*16 +: 16];
						else
							vol_q[i+1] <= ch_word[i*16 +: 7];
						phase_q[i] <= ~phase_q[i] & ~wrap_pend_q[i];
						wrap_pend_q[i] <= 1'b0;
					end else if (vol_att[i]) begin
						vol_q[i+1] <= ch_word[i*16 +: 7];
					end else if (per_att[i]) begin
						per_q[i+1] <= ch_word[i*16 +: 16];
					end
				end
				if (!run[i] || !(vol_att[i] && per_att[i])) begin
					phase_q[i] <= 1'b0;
					wrap_pend_q[i] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB read, outputs
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h0000_0000;
		if (in_ch) begin
			case (ch_fld)
			`ACM_CH_OFF_LOC: rd_d = {14'h0000, loc_q[ch_idx]};
			`ACM_CH_OFF_LEN: rd_d = {16'h0000, len_q[ch_idx]};
			`ACM_CH_OFF_PER: rd_d = {16'h0000, per_q[ch_idx]};
			default:         rd_d = {25'h000_0000, vol_q[ch_idx]};
			endcase
		end else begin
			case (paddr_i)
			`ACM_OFF_ATTACH:   rd_d = {16'h0000, attach_q};
			`ACM_OFF_DMA_CTRL: rd_d = {16'h0000, dma_ctrl_q};
			`ACM_OFF_FILTER:   rd_d = {30'h0000_0000, filter_bypass_control_o, 1'b0};
			`ACM_OFF_IRQ_STAT: rd_d = {28'h000_0000, irq_stat_q};
			`ACM_OFF_IRQ_MASK: rd_d = {28'h000_0000, irq_mask_q};
			default:           rd_d = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
			fetch_req_o <= 4'h0;
			fetch_addr_o <= 72'h00_0000_0000_0000_0000;
			dac_sample_o <= 32'h0000_0000;
			dac_volume_o <= 28'h000_0000;
		end else begin
			// Zero-wait slave: ready in the access cycle
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
			prdata_o <= (psel_i && !penable_i && !pwrite_i && mapped) ? rd_d : 32'h0000_0000;
			irq_o <= |(irq_stat_q & irq_mask_q);
			fetch_req_o <= ch_req;
			fetch_addr_o <= ch_addr;
			for (i = 0; i < 4; i = i + 1) begin
				// Attached channel is muted
				if (vol_att[i] || per_att[i] || !run[i]) begin
					dac_sample_o[i*8 +: 8] <= 8'h00;
					dac_volume_o[i*7 +: 7] <= 7'h00;
				end else begin
					dac_sample_o[i*8 +: 8] <= ch_bsel[i] ? ch_word[i*16 +: 8] :
						ch_word[i*16+8 +: 8];
					dac_volume_o[i*7 +: 7] <= vol_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/acm_top_assertions.sv */
// Checker for the acm_top ports.
// Bound to acm_top; APB writes are shadowed here.
`timescale 1ns/1ps
`default_nettype none
module acm_chk (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [3:0]  fetch_req_o,
	input wire logic [31:0] dac_sample_o,
	input wire logic [27:0] dac_volume_o,
	input wire logic        filter_bypass_control_o
);
	logic [7:0] att_q;
	logic       dma_q;
	logic       flt_q;
	wire        wr = psel_i & penable_i & pready_o & pwrite_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			att_q <= 8'h00;
			dma_q <= 1'b0;
			flt_q <= 1'b0;
		end else if (wr) begin
			if (paddr_i == 8'h00)
				att_q <= pwdata_i[7:0];
			if (paddr_i == 8'h04)
				dma_q <= pwdata_i[9];
			if (paddr_i == 8'h08)
				flt_q <= pwdata_i[1];
		end
	end
	////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_wr_filter;
		wr && paddr_i == 8'h08;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready_o)
		else $error("pready missing");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready too long");
	a_err_read_zero: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 0))
		else $error("bad error reply");
	a_mute_chan0: assert property ($past(att_q[0] | att_q[4], 2) && $past(att_q[0] | att_q[4])
		|-> dac_volume_o[6:0] == 0 && dac_sample_o[7:0] == 0) else $error("ch0 audible");
	a_mute_chan3: assert property ($past(att_q[3] | att_q[7], 2) && $past(att_q[3] | att_q[7])
		|-> dac_volume_o[27:21] == 0 && dac_sample_o[31:24] == 0) else $error("ch3 audible");
	a_fetch_pulse: assert property (fetch_req_o != 0 |=> (fetch_req_o & $past(fetch_req_o)) == 0)
		else $error("fetch request held");
	a_dma_gate: assert property (!$past(dma_q, 2) && !$past(dma_q) |-> fetch_req_o == 0)
		else $error("fetch without master enable");
	a_filter_follow: assert property (s_wr_filter |-> ##2 filter_bypass_control_o == flt_q)
		else $error("filter bypass wrong");
endmodule
bind acm_top acm_chk i_acm_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.fetch_req_o(fetch_req_o), .dac_sample_o(dac_sample_o), .dac_volume_o(dac_volume_o),
	.filter_bypass_control_o(filter_bypass_control_o));
`default_nettype wire

/* tb/acm_mem_model.sv */
// Memory answering per-channel fetches; word = 16'hff80 | addr[6:0].
// Assumes one request per channel outstanding; slow_i adds waits.
`timescale 1ns/1ps
`default_nettype none
module acm_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic [3:0]  req_i,
	input  wire logic [71:0] addr_i,
	output wire logic [3:0]  ack_o,
	output wire logic [63:0] data_o
);
	for (genvar g = 0; g < 4; g++) begin : g_ch
		logic        pend_q;
		logic        ack_q;
		logic [2:0]  wait_q;
		logic [17:0] adr_q;
		logic [15:0] dat_q;
		assign ack_o[g] = ack_q;
		assign data_o[g*16+:16] = dat_q;
		always @(posedge clk_i) begin
			ack_q <= 1'b0;
			dat_q <= ~dat_q;
			if (rst_i) begin
				pend_q <= 1'b0;
				dat_q <= 16'h5a5a;
			end else if (req_i[g]) begin
				pend_q <= 1'b1;
				adr_q <= addr_i[g*18+:18];
				wait_q <= slow_i ? 3'd5 : 3'd0;
			end else if (pend_q && wait_q != 3'd0)
				wait_q <= wait_q - 3'd1;
			else if (pend_q) begin
				pend_q <= 1'b0;
				ack_q <= 1'b1;
				dat_q <= {9'h1ff, adr_q[6:0]};
			end
		end
	end
endmodule
`default_nettype wire

/* tb/test_acm_top.sv */
// Directed APB tests of acm_top with a memory model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.vh"
module test_acm_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd, smp;
	logic        pready, perr, fbc, irq, er;
	logic [3:0]  freq, fack;
	logic [71:0] faddr;
	logic [63:0] fdata;
	logic [27:0] vol;
	int          err_total = 0;
	int          checks = 0;
	always #2 clk = ~clk;
	acm_top i_acm_top (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .fetch_req_o(freq), .fetch_addr_o(faddr),
		.fetch_ack_i(fack), .fetch_data_i(fdata), .dac_sample_o(smp), .dac_volume_o(vol),
		.filter_bypass_control_o(fbc), .irq_o(irq));
	acm_mem_model i_acm_mem_model (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(freq),
		.addr_i(faddr), .ack_o(fack), .data_o(fdata));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		chk("pready", 1, 32'(pready));
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic set_ch(input int g, input logic [15:0] loc, len, per, v);
		logic [7:0] b;
		b = `ACM_OFF_CH_BASE + 8'(g * 16);
		apb(1, b, 32'(loc));
		apb(1, b + 8'h04, 32'(len));
		apb(1, b + 8'h08, 32'(per));
		apb(1, b + 8'h0c, 32'(v));
	endtask
	task automatic wait_vol(input int g, input logic [6:0] v);
		int n;
		n = 0;
		while (vol[g*7+:7] !== v && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("volume", 32'(v), 32'(vol[g*7+:7]));
	endtask
	task automatic wait_smp(input int g, input logic [7:0] v);
		int n;
		n = 0;
		while (smp[g*8+:8] !== v && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("sample", 32'(v), 32'(smp[g*8+:8]));
	endtask
	task automatic wrap_up;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		apb(0, `ACM_OFF_ATTACH, 0);
		chk("attach_rst", 0, rd);
		apb(1, `ACM_OFF_ATTACH, 32'h0000_00ff);
		apb(0, `ACM_OFF_ATTACH, 0);
		chk("attach_rw", 32'h0000_00ff, rd);
		apb(0, 8'hfc, 0);
		chk("unmapped", 32'h0000_0001, {rd[30:0], er});
		apb(1, `ACM_OFF_FILTER, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("filter", 1, 32'(fbc));
		set_ch(0, 16'h0010, 16'h0002, 16'h0002, 16'h0000);
		set_ch(1, 16'h0040, 16'h0004, 16'h007c, 16'h007f);
		set_ch(2, 16'h0020, 16'h0003, 16'h0002, 16'h0033);
		set_ch(3, 16'h0060, 16'h0004, 16'h0002, 16'h007f);
		apb(1, `ACM_OFF_ATTACH, 32'h0000_0045);
		apb(1, `ACM_OFF_DMA_CTRL, 32'h0000_020f);
		repeat (4) @(posedge clk);
		chk("irq_masked", 0, 32'(irq));
		apb(0, `ACM_OFF_IRQ_STAT, 0);
		chk("irq_status", 32'h0000_000f, rd);
		apb(1, `ACM_OFF_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("irq_on", 1, 32'(irq));
		apb(1, `ACM_OFF_IRQ_STAT, 32'h0000_000f);
		repeat (2) @(posedge clk);
		chk("irq_clear", 0, 32'(irq));
		chk("ch0_mute", 0, 32'({vol[6:0], smp[7:0]}));
		wait_vol(3, 7'h22);
		apb(0, 8'h58, 0);
		chk("period", 32'h0000_ffa1, {16'h0000, rd[15:0]});
		wait_vol(3, 7'h20);
		apb(0, 8'h58, 0);
		chk("period_kept", 32'h0000_ffa1, {16'h0000, rd[15:0]});
		slow <= 1'b1;
		wait_vol(1, 7'h10);
		wait_vol(1, 7'h11);
		wait_vol(1, 7'h10);
		apb(1, `ACM_OFF_ATTACH, 32'h0000_0008);
		repeat (4) @(posedge clk);
		chk("ch3_mute", 0, 32'(vol[27:21]));
		chk("ch2_plays", 32'h0000_0033, 32'(vol[20:14]));
		wait_smp(2, 8'ha1);
		apb(1, `ACM_OFF_DMA_CTRL, 32'h0000_000f);
		repeat (4) @(posedge clk);
		chk("stopped", 0, 32'(vol));
		wrap_up();
	end
endmodule
`default_nettype wire
